// ===== cksc_pkg.sv
// Package for the clock speed control and reset entry block
package cksc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CKSC_CLOCK_SPEED_CONTROL_ADDR = 8'h8F;
  localparam logic [7:0] CKSC_CLOCK_SPEED_CONTROL_RESET = 8'h00;

  localparam int CKSC_CAN_SPEED_BIT = 7;
  localparam int CKSC_WATCHDOG_SPEED_BIT = 6;
  localparam int CKSC_COUNTER_ARRAY_SPEED_BIT = 5;
  localparam int CKSC_SERIAL_SPEED_BIT = 4;
  localparam int CKSC_TIMER2_SPEED_BIT = 3;
  localparam int CKSC_TIMER1_SPEED_BIT = 2;
  localparam int CKSC_TIMER0_SPEED_BIT = 1;
  localparam int CKSC_CPU_DOUBLE_SPEED_BIT = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [3:0] CKSC_STD_PERIODS = 4'hC;
  localparam logic [3:0] CKSC_X2_PERIODS = 4'h6;
  localparam int CKSC_WARM_RESET_OSC_PERIODS = 24;
  localparam int CKSC_PERIPH_COUNT = 7;

  // Serial modes affected by serial_speed
  localparam logic [1:0] CKSC_SERIAL_MODE_SHIFT = 2'h0;
  localparam logic [1:0] CKSC_SERIAL_MODE_FIXED = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cksc_sfr_req_type;

  typedef struct packed {
    logic can;
    logic watchdog;
    logic counter_array;
    logic serial;
    logic timer2;
    logic timer1;
    logic timer0;
  } cksc_periph_type;

  typedef struct packed {
    logic watchdog;
    logic counter_array;
    logic timer;
  } cksc_int_reset_type;

  typedef enum logic [1:0] {
    CKSC_RST_RUN = 2'b01,
    CKSC_RST_HOLD = 2'b10
  } cksc_rst_state_type;

endpackage : cksc_pkg

// ===== cksc_clock_speed_mode_and_reset_entry.sv
// Clock speed control register, rate enables and reset entry
`timescale 1ns/1ns
`default_nettype none

module cksc_clock_speed_mode_and_reset_entry
  import cksc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reset_pin,
  input wire cksc_int_reset_type int_reset_req,
  input wire cksc_sfr_req_type sfr_req,
  input wire logic [1:0] serial_mode,
  output logic [7:0] sfr_rdata,
  output logic core_reset,
  output logic cpu_cycle_en,
  output cksc_periph_type periph_cycle_en,
  output logic cpu_double_speed_active,
  output logic [3:0] cpu_periods
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Cycle length in oscillator periods for a given speed choice
  function automatic logic [3:0] cksc_len(input logic fast);
    cksc_len = fast ? CKSC_X2_PERIODS : CKSC_STD_PERIODS;
  endfunction : cksc_len

  function automatic logic [3:0] cksc_step(input logic [3:0] cnt,
                                           input logic [3:0] len);
    cksc_step = (cnt >= len - 4'h1) ? 4'h0 : cnt + 4'h1;
  endfunction : cksc_step

  // ----------------------------------------------------------------
  // Reset entry
  // ----------------------------------------------------------------
  logic reset_pin_r;
  logic int_req_r;
  cksc_rst_state_type rst_state_r;
  cksc_rst_state_type rst_state_nxt;
  wire logic any_reset_req;

  // Caller holds the pin for 24 periods; one high sample suffices here
  assign any_reset_req = reset_pin_r | int_req_r;

  always_comb
  begin
    case (rst_state_r)
      CKSC_RST_RUN: rst_state_nxt = any_reset_req ? CKSC_RST_HOLD
                                                   : CKSC_RST_RUN;
      CKSC_RST_HOLD: rst_state_nxt = any_reset_req ? CKSC_RST_HOLD
                                                    : CKSC_RST_RUN;
      default: rst_state_nxt = CKSC_RST_HOLD;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reset_pin_r <= 1'b0;
      int_req_r <= 1'b0;
      rst_state_r <= CKSC_RST_HOLD;
    end
    else
    begin
      reset_pin_r <= reset_pin;
      int_req_r <= |int_reset_req;
      rst_state_r <= rst_state_nxt;
    end
  end

  wire logic sync_reset;
  assign sync_reset = (rst_state_r == CKSC_RST_HOLD);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [7:0] clock_speed_control_r;
  wire logic reg_hit;
  wire logic reg_write;
  assign reg_hit = (sfr_req.addr == CKSC_CLOCK_SPEED_CONTROL_ADDR);
  assign reg_write = sfr_req.wr & reg_hit;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      clock_speed_control_r <= CKSC_CLOCK_SPEED_CONTROL_RESET;
    else if (sync_reset)
      clock_speed_control_r <= CKSC_CLOCK_SPEED_CONTROL_RESET;
    else if (reg_write)
      clock_speed_control_r <= sfr_req.wdata;
  end

  // Unmapped addresses read zero
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sfr_rdata <= 8'h00;
    else
      sfr_rdata <= (sfr_req.rd && reg_hit) ? clock_speed_control_r : 8'h00;
  end

  // ----------------------------------------------------------------
  // Oscillator divide by two and mode validation
  // ----------------------------------------------------------------
  // The clock input is the oscillator; osc_half marks its /2 rising edge
  logic osc_half_r;
  logic x2_active_r;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      osc_half_r <= 1'b0;
      x2_active_r <= 1'b0;
    end
    else if (sync_reset)
    begin
      osc_half_r <= 1'b0;
      x2_active_r <= 1'b0;
    end
    else
    begin
      osc_half_r <= ~osc_half_r;
      // Sample only at the /2 edge so a switch never cuts a half cycle
      if (!osc_half_r)
        x2_active_r <= clock_speed_control_r[CKSC_CPU_DOUBLE_SPEED_BIT];
    end
  end
  assign cpu_double_speed_active = x2_active_r;

  // ----------------------------------------------------------------
  // Effective speed choices
  // ----------------------------------------------------------------
  wire logic [CKSC_PERIPH_COUNT-1:0] periph_fast;
  wire logic serial_rate_mode;
  assign serial_rate_mode = (serial_mode == CKSC_SERIAL_MODE_SHIFT) ||
                            (serial_mode == CKSC_SERIAL_MODE_FIXED);

  // Fast only with double speed on and the peripheral bit clear
  genvar gi;
  generate
    for (gi = 0; gi < CKSC_PERIPH_COUNT; gi++)
    begin : g_fast
      if (gi + 1 == CKSC_SERIAL_SPEED_BIT)
        assign periph_fast[gi] = x2_active_r & serial_rate_mode &
                                 ~clock_speed_control_r[gi+1];
      else
        assign periph_fast[gi] = x2_active_r &
                                 ~clock_speed_control_r[gi+1];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Cycle counters and enables
  // ----------------------------------------------------------------
  logic [3:0] cpu_cnt_r;
  logic [3:0] per_cnt_r [CKSC_PERIPH_COUNT];
  logic [CKSC_PERIPH_COUNT-1:0] per_en_r;
  wire logic [3:0] cpu_len;
  assign cpu_len = cksc_len(x2_active_r);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpu_cnt_r <= 4'h0;
      cpu_cycle_en <= 1'b0;
      cpu_periods <= CKSC_STD_PERIODS;
    end
    else if (sync_reset)
    begin
      cpu_cnt_r <= 4'h0;
      cpu_cycle_en <= 1'b0;
      cpu_periods <= CKSC_STD_PERIODS;
    end
    else
    begin
      cpu_cnt_r <= cksc_step(cpu_cnt_r, cpu_len);
      cpu_cycle_en <= (cpu_cnt_r >= cpu_len - 4'h1);
      cpu_periods <= cpu_len;
    end
  end

  generate
    for (gi = 0; gi < CKSC_PERIPH_COUNT; gi++)
    begin : g_per
      wire logic [3:0] len;
      assign len = cksc_len(periph_fast[gi]);
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          per_cnt_r[gi] <= 4'h0;
          per_en_r[gi] <= 1'b0;
        end
        else if (sync_reset)
        begin
          per_cnt_r[gi] <= 4'h0;
          per_en_r[gi] <= 1'b0;
        end
        else
        begin
          per_cnt_r[gi] <= cksc_step(per_cnt_r[gi], len);
          per_en_r[gi] <= (per_cnt_r[gi] >= len - 4'h1);
        end
      end
    end
  endgenerate

  // Bit order of the struct matches register bits 7..1
  assign periph_cycle_en = per_en_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      core_reset <= 1'b1;
    else
      core_reset <= sync_reset;
  end

endmodule : cksc_clock_speed_mode_and_reset_entry
`default_nettype wire

// ===== cksc_asserts.sv
// Checker for the clock speed control and reset entry block
`timescale 1ns/1ns
`default_nettype none
module cksc_asserts
  import cksc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reset_pin,
  input wire cksc_int_reset_type int_reset_req,
  input wire cksc_sfr_req_type sfr_req,
  input wire logic [1:0] serial_mode,
  input wire logic [7:0] sfr_rdata,
  input wire logic core_reset,
  input wire logic cpu_cycle_en,
  input wire cksc_periph_type periph_cycle_en,
  input wire logic cpu_double_speed_active,
  input wire logic [3:0] cpu_periods
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_std;
    !cpu_double_speed_active && !$past(cpu_double_speed_active)
      |-> cpu_periods == CKSC_STD_PERIODS;
  endproperty
  a_std: assert property (p_std) else $error("std length");
  property p_dbl;
    cpu_double_speed_active && $past(cpu_double_speed_active)
      |-> cpu_periods == CKSC_X2_PERIODS;
  endproperty
  a_dbl: assert property (p_dbl) else $error("double length");
  property p_gap;
    cpu_cycle_en && !core_reset |=> ##[0:11] (cpu_cycle_en || core_reset);
  endproperty
  a_gap: assert property (p_gap) else $error("cycle gap");
  property p_pin;
    reset_pin |-> ##[1:3] core_reset;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset");
  property p_int;
    |int_reset_req |-> ##[1:3] core_reset;
  endproperty
  a_int: assert property (p_int) else $error("internal reset");
  property p_merge;
    (!reset_pin && int_reset_req == 3'h0) [*4] |-> !core_reset;
  endproperty
  a_merge: assert property (p_merge) else $error("reset stuck");
  property p_quiet;
    core_reset && $past(core_reset) |-> !cpu_cycle_en && periph_cycle_en == 7'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("enable in reset");
  property p_rdz;
    sfr_req.rd && sfr_req.addr != CKSC_CLOCK_SPEED_CONTROL_ADDR
      |=> sfr_rdata == 8'h00;
  endproperty
  a_rdz: assert property (p_rdz) else $error("unmapped read");
  property p_clr;
    core_reset [*4] |-> !cpu_double_speed_active;
  endproperty
  a_clr: assert property (p_clr) else $error("mode kept");
  property p_glitch;
    $changed(cpu_double_speed_active) |=> $stable(cpu_double_speed_active);
  endproperty
  a_glitch: assert property (p_glitch) else $error("mode glitch");
endmodule : cksc_asserts
bind cksc_clock_speed_mode_and_reset_entry cksc_asserts u_chk (
  .clock(clock), .rst_b(rst_b), .reset_pin(reset_pin),
  .int_reset_req(int_reset_req), .sfr_req(sfr_req),
  .serial_mode(serial_mode), .sfr_rdata(sfr_rdata),
  .core_reset(core_reset), .cpu_cycle_en(cpu_cycle_en),
  .periph_cycle_en(periph_cycle_en), .cpu_periods(cpu_periods),
  .cpu_double_speed_active(cpu_double_speed_active));
`default_nettype wire

// ===== cksc_clock_speed_mode_and_reset_entry_tb_top.sv
// Self-checking bench for the clock speed control block
`timescale 1ns/1ns
`default_nettype none
module cksc_clock_speed_mode_and_reset_entry_tb_top import cksc_pkg::*;;
  localparam logic [7:0] A = CKSC_CLOCK_SPEED_CONTROL_ADDR;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic reset_pin = 1'b0;
  logic [1:0] serial_mode = 2'h0;
  cksc_int_reset_type int_reset_req = '0;
  cksc_sfr_req_type sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic core_reset, cpu_cycle_en, cpu_double_speed_active;
  cksc_periph_type periph_cycle_en;
  logic [3:0] cpu_periods;
  int n_fail = 0;
  int checked = 0;
  int n_hi = 0;
  // Rows: serial mode above, register value below
  logic [9:0] rows [7] = '{10'h000, 10'h0FE, 10'h001, 10'h101, 10'h301,
    10'h2AB, 10'h0D5};
  cksc_clock_speed_mode_and_reset_entry u_dut (.clock(clock), .rst_b(rst_b),
    .reset_pin(reset_pin), .int_reset_req(int_reset_req), .sfr_req(sfr_req),
    .serial_mode(serial_mode), .sfr_rdata(sfr_rdata),
    .core_reset(core_reset), .cpu_cycle_en(cpu_cycle_en),
    .periph_cycle_en(periph_cycle_en), .cpu_periods(cpu_periods),
    .cpu_double_speed_active(cpu_double_speed_active));
  initial forever #5 clock = ~clock;
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  // One bus cycle per call; idle cycle lowers the strobes
  task automatic req(input logic [7:0] a, d, input logic w, r);
    sfr_req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge clock);
  endtask : req
  task automatic wr(input logic [7:0] a, d);
    req(a, d, 1'b1, 1'b0);
    req(8'h00, 8'h00, 1'b0, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    req(a, 8'h00, 1'b0, 1'b1);
    chk("read data", e, sfr_rdata);
    req(8'h00, 8'h00, 1'b0, 1'b0);
  endtask : rd
  // Window of 120 clocks holds exactly 10 slow or 20 fast pulses
  task automatic rate(input logic [7:0] d, input logic [1:0] m);
    int c [8];
    logic [6:0] fast;
    c = '{default: 0};
    fast = d[0] ? ~d[7:1] : 7'h00;
    if (m[0])
      fast[3] = 1'b0;
    repeat (120)
    begin
      @(negedge clock);
      c[7] += cpu_cycle_en;
      for (int k = 0; k < 7; k++) c[k] += periph_cycle_en[k];
    end
    chk("cpu cycles", d[0] ? 8'h14 : 8'h0A, 8'(c[7]));
    for (int k = 0; k < 7; k++)
      chk("periph cycles", fast[k] ? 8'h14 : 8'h0A, 8'(c[k]));
  endtask : rate
  initial
  begin
    #50000;
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    cyc(4);
    chk("core_reset", 8'h01, {7'h00, core_reset});
    rst_b <= 1'b1;
    cyc(4);
    rd(A, 8'h00);
    foreach (rows[i])
    begin
      serial_mode <= rows[i][9:8];
      wr(A, rows[i][7:0]);
      rd(A, rows[i][7:0]);
      cyc(24);
      rate(rows[i][7:0], rows[i][9:8]);
    end
    wr(8'h8E, 8'hFF);
    rd(8'h8E, 8'h00);
    rd(A, 8'hD5);
    wr(A, 8'h00);
    req(A, 8'h01, 1'b1, 1'b0);
    req(A, 8'h00, 1'b1, 1'b0);
    // One-cycle set: a /2-edge capture stands two cycles, never one
    repeat (4)
    begin
      n_hi += cpu_double_speed_active;
      req(8'h00, 8'h00, 1'b0, 1'b0);
    end
    cyc(4);
    chk("double active", 8'h00, {7'h00, cpu_double_speed_active});
    chk("double pulse parity", 8'h00, {7'h00, n_hi[0]});
    wr(A, 8'hFF);
    reset_pin <= 1'b1;
    cyc(24);
    chk("core_reset", 8'h01, {7'h00, core_reset});
    reset_pin <= 1'b0;
    cyc(6);
    chk("core_reset", 8'h00, {7'h00, core_reset});
    rd(A, 8'h00);
    for (int b = 0; b < 3; b++)
    begin
      wr(A, 8'h01);
      int_reset_req <= 3'h1 << b;
      cyc(3);
      chk("core_reset", 8'h01, {7'h00, core_reset});
      int_reset_req <= '0;
      cyc(6);
      rd(A, 8'h00);
    end
    wr(A, 8'h01);
    cyc(6);
    rst_b <= 1'b0;
    cyc(2);
    chk("cpu periods", 8'h0C, {4'h0, cpu_periods});
    rst_b <= 1'b1;
    cyc(4);
    tally_and_finish();
  end
endmodule : cksc_clock_speed_mode_and_reset_entry_tb_top
`default_nettype wire
